// >>> tap_instruction_and_debug_channel.v
// test access port instruction decode, data register scan and debug channel word
`timescale 1ns/1ps
`default_nettype none
`include "tap_debug_map.vh"
module tap_instruction_and_debug_channel
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire       tckPin,
	input  wire       tmsPin,
	input  wire       tdiPin,
	output reg        tdoOut,
	output reg        tdoOe,
	input  wire [1:0] engineStatus,
	input  wire [7:0] engineTxByte,
	input  wire       engineTxLoad,
	output reg  [7:0] debug_buffer_register,
	output reg        rxByteValid,
	output reg  [2:0] progWord,
	output reg        progWordValid,
	input  wire [2:0] progReadback,
	output reg  [2:0] instruction,
	output reg        debugActive,
	output reg        programActive
);
	// ------------------------------------------------------------------
	// reset release and pin synchronisation
	// ------------------------------------------------------------------
	reg rstMeta_q;
	reg rstSync_q;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	wire rstN = rstSync_q;
	wire tckRise;
	wire tckFall;
	wire tmsLevel;
	wire tdiLevel;

	sync_edge tckSync
	(
		.clk   (clk),
		.rstN  (rstN),
		.pinIn (tckPin),
		.level (),
		.rise  (tckRise),
		.fall  (tckFall)
	);

	sync_edge tmsSync
	(
		.clk   (clk),
		.rstN  (rstN),
		.pinIn (tmsPin),
		.level (tmsLevel),
		.rise  (),
		.fall  ()
	);

	sync_edge tdiSync
	(
		.clk   (clk),
		.rstN  (rstN),
		.pinIn (tdiPin),
		.level (tdiLevel),
		.rise  (),
		.fall  ()
	);

	// ------------------------------------------------------------------
	// controller
	// ------------------------------------------------------------------
	wire [3:0] state;

	// steps only on tck rises, tms high walks to reset within five
	tap_fsm fsm
	(
		.clk      (clk),
		.rstN     (rstN),
		.tckRise  (tckRise),
		.tmsLevel (tmsLevel),
		.state    (state)
	);

	reg inReset;
	reg inShiftDr;
	reg inShiftIr;
	reg inCapDr;
	reg inCapIr;
	reg inUpdDr;
	reg inUpdIr;

	// flags for the states that act on the scan registers; the rest do nothing here
	always @*
	begin
		inReset   = 1'b0;
		inShiftDr = 1'b0;
		inShiftIr = 1'b0;
		inCapDr   = 1'b0;
		inCapIr   = 1'b0;
		inUpdDr   = 1'b0;
		inUpdIr   = 1'b0;
		case (state)
			`ST_RESET:    inReset   = 1'b1;
			`ST_SHIFT_DR: inShiftDr = 1'b1;
			`ST_SHIFT_IR: inShiftIr = 1'b1;
			`ST_CAP_DR:   inCapDr   = 1'b1;
			`ST_CAP_IR:   inCapIr   = 1'b1;
			`ST_UPD_DR:   inUpdDr   = 1'b1;
			`ST_UPD_IR:   inUpdIr   = 1'b1;
			default:      inReset   = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// instruction register and data register selection
	// ------------------------------------------------------------------
	reg [2:0] irShift_q;
	reg [1:0] select_q;
	reg [1:0] selectNew;

	always @*
	begin
		selectNew = select_q;
		case (irShift_q)
			`IR_DEBUG:       selectNew = `SEL_DEBUG;
			`IR_PROGRAM:     selectNew = `SEL_PROGRAM;
			`IR_BYPASS:      selectNew = `SEL_BYPASS;
			`IR_BYPASS_ALT1: selectNew = `SEL_BYPASS;
			`IR_BYPASS_ALT2: selectNew = `SEL_BYPASS;
			default:         selectNew = select_q;
		endcase
	end

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			irShift_q   <= `IR_CAPTURE_PAT;
			instruction <= `IR_RESET_VALUE;
			select_q    <= `SEL_BYPASS;
		end
		else if (inReset)
		begin
			instruction <= `IR_RESET_VALUE;
			select_q    <= `SEL_BYPASS;
		end
		else
		begin
			if (tckRise && inCapIr)
				irShift_q <= `IR_CAPTURE_PAT;
			else if (tckRise && inShiftIr)
				irShift_q <= {tdiLevel, irShift_q[2:1]};
			// only an IR update or the reset state changes the instruction
			if (tckFall && inUpdIr)
			begin
				instruction <= irShift_q;
				select_q    <= selectNew;
			end
		end
	end

	always @*
	begin
		debugActive   = (select_q == `SEL_DEBUG);
		programActive = (select_q == `SEL_PROGRAM);
	end

	// ------------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------------
	reg                  bypass_q;
	reg [`DBG_WIDTH-1:0] dbgShift_q;
	reg [2:0]            progShift_q;
	reg [1:0]            status_q;

	// ten-bit word: status in bits 1:0, byte in bits 9:2, lsb first
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			bypass_q    <= 1'b0;
			dbgShift_q  <= {`DBG_WIDTH{1'b0}};
			progShift_q <= 3'h0;
			status_q    <= 2'h0;
		end
		else
		begin
			status_q <= engineStatus;
			if (tckRise && inCapDr && select_q == `SEL_BYPASS)
				bypass_q <= 1'b0;
			if (tckRise && inShiftDr)
			begin
				case (select_q)
					`SEL_DEBUG:   dbgShift_q  <= {tdiLevel, dbgShift_q[`DBG_WIDTH-1:1]};
					`SEL_PROGRAM: progShift_q <= {tdiLevel, progShift_q[2:1]};
					default:      bypass_q    <= tdiLevel;
				endcase
			end
			else if (tckFall && inUpdDr)
			begin
				// reload from the parallel side for the next scan
				if (select_q == `SEL_DEBUG)
					dbgShift_q <= {debug_buffer_register, status_q};
				else if (select_q == `SEL_PROGRAM)
					progShift_q <= progReadback;
			end
		end
	end

	// ------------------------------------------------------------------
	// parallel buffers
	// ------------------------------------------------------------------
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			debug_buffer_register <= 8'h00;
			rxByteValid           <= 1'b0;
			progWord              <= 3'h0;
			progWordValid         <= 1'b0;
		end
		else
		begin
			rxByteValid   <= 1'b0;
			progWordValid <= 1'b0;
			if (tckFall && inUpdDr && select_q == `SEL_DEBUG)
			begin
				// one shared buffer for both directions
				debug_buffer_register <= dbgShift_q[`DBG_BYTE_MSB:`DBG_BYTE_LSB];
				rxByteValid           <= 1'b1;
			end
			else if (engineTxLoad)
				debug_buffer_register <= engineTxByte;
			if (tckFall && inUpdDr && select_q == `SEL_PROGRAM)
			begin
				progWord      <= progShift_q;
				progWordValid <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// test data output
	// ------------------------------------------------------------------
	reg serialBit;

	always @*
	begin
		serialBit = bypass_q;
		if (inShiftIr)
			serialBit = irShift_q[0];
		else if (select_q == `SEL_DEBUG)
			serialBit = dbgShift_q[0];
		else if (select_q == `SEL_PROGRAM)
			serialBit = progShift_q[0];
	end

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			tdoOut <= 1'b1;
			tdoOe  <= 1'b0;
		end
		else if (tckFall)
		begin
			tdoOut <= serialBit;
			tdoOe  <= inShiftIr | inShiftDr;
		end
	end
endmodule
`default_nettype wire

// >>> tap_debug_map.vh
// instruction, select, state code and layout constants for the test access port and debug channel
`ifndef TAP_DEBUG_MAP_VH
`define TAP_DEBUG_MAP_VH

`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_SAMPLE       3'h1
`define IR_DEBUG        3'h2
`define IR_BYPASS       3'h3
`define IR_PROGRAM      3'h4
`define IR_BYPASS_ALT1  3'h5
`define IR_BYPASS_ALT2  3'h7
`define IR_CAPTURE_PAT  3'h1
`define IR_RESET_VALUE  3'h3

`define DBG_WIDTH       10
`define DBG_STATUS_LSB  0
`define DBG_STATUS_MSB  1
`define DBG_BYTE_LSB    2
`define DBG_BYTE_MSB    9
`define PROG_WIDTH      3

`define SEL_BYPASS      2'h0
`define SEL_DEBUG       2'h1
`define SEL_PROGRAM     2'h2

`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SHIFT_DR     4'h4
`define ST_EXIT1_DR     4'h5
`define ST_PAUSE_DR     4'h6
`define ST_EXIT2_DR     4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SHIFT_IR     4'hB
`define ST_EXIT1_IR     4'hC
`define ST_PAUSE_IR     4'hD
`define ST_EXIT2_IR     4'hE
`define ST_UPD_IR       4'hF

`endif

// >>> sync_edge.v
// two-flop synchroniser with rise and fall pulses for one pin
`timescale 1ns/1ps
`default_nettype none
module sync_edge
(
	input  wire clk,
	input  wire rstN,
	input  wire pinIn,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule
`default_nettype wire

// >>> tap_fsm.v
// sixteen-state test access port controller advanced on test clock rising edges
`timescale 1ns/1ps
`default_nettype none
`include "tap_debug_map.vh"
module tap_fsm
(
	input  wire       clk,
	input  wire       rstN,
	input  wire       tckRise,
	input  wire       tmsLevel,
	output wire [3:0] state
);
	reg [3:0] state_q;
	reg [3:0] state_d;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always @*
	begin
		state_d = state_q;
		case (state_q)
			`ST_RESET:    state_d = tmsLevel ? `ST_RESET : `ST_IDLE;
			`ST_IDLE:     state_d = tmsLevel ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR:   state_d = tmsLevel ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR:   state_d = tmsLevel ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: state_d = tmsLevel ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: state_d = tmsLevel ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: state_d = tmsLevel ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: state_d = tmsLevel ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR:   state_d = tmsLevel ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR:   state_d = tmsLevel ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR:   state_d = tmsLevel ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: state_d = tmsLevel ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: state_d = tmsLevel ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: state_d = tmsLevel ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: state_d = tmsLevel ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR:   state_d = tmsLevel ? `ST_SEL_DR : `ST_IDLE;
			default:      state_d = `ST_RESET;
		endcase
	end

	// state moves only on a test clock rise, so a stopped clock holds it
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			state_q <= `ST_RESET;
		else if (tckRise)
			state_q <= state_d;
	end

	assign state = state_q;
endmodule
`default_nettype wire

// >>> tap_instruction_and_debug_channel_props.sv
// checker for scan timing and instruction decode at the tap block ports
`timescale 1ns/1ps
`default_nettype none
module tap_instruction_and_debug_channel_props
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       tckPin,
	input wire logic       tdoOut,
	input wire logic       tdoOe,
	input wire logic       engineTxLoad,
	input wire logic [7:0] debug_buffer_register,
	input wire logic       rxByteValid,
	input wire logic [2:0] progWord,
	input wire logic       progWordValid,
	input wire logic [2:0] instruction,
	input wire logic       debugActive,
	input wire logic       programActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------
	// scan pin timing, select decode and update pulses
	// ----------------
	chk_tdo_on_fall:
		assert property ($changed({tdoOut, tdoOe}) |-> !$past(tckPin, 1) && $past(tckPin, 6))
		else $error("tdo moved away from a test clock fall");
	chk_ir_on_edge:
		assert property ($changed(instruction) |-> $past(tckPin, 1) != $past(tckPin, 6))
		else $error("instruction moved without a test clock edge");
	chk_debug_select:
		assert property (instruction == 3'h2 |-> ##[0:1] (debugActive && !programActive))
		else $error("debug code did not select the ten-bit register");
	chk_prog_select:
		assert property (instruction == 3'h4 |-> ##[0:1] (programActive && !debugActive))
		else $error("programming code did not select the three-bit register");
	chk_bypass_select:
		assert property ((instruction == 3'h3 || instruction == 3'h5 || instruction == 3'h7)
			|-> ##[0:1] !(debugActive || programActive))
		else $error("bypass code did not select the bypass cell");
	chk_buf_cause:
		assert property ($changed(debug_buffer_register) && !$past(engineTxLoad) |-> ##[0:1] rxByteValid)
		else $error("debug buffer changed without a cause");
	chk_rx_pulse:
		assert property (rxByteValid |-> debugActive ##1 !rxByteValid)
		else $error("receive pulse too long or outside debug");
	chk_prog_pulse:
		assert property (progWordValid |-> programActive ##1 !progWordValid)
		else $error("program word pulse too long or outside programming");
	chk_prog_update:
		assert property ($changed(progWord) |-> ##[0:1] progWordValid)
		else $error("program word changed without its pulse");
	cover property (rxByteValid);
	cover property (progWordValid);
	cover property (tdoOe && debugActive);
endmodule
bind tap_instruction_and_debug_channel tap_instruction_and_debug_channel_props u_props (.*);
`default_nettype wire

// >>> scan_host.sv
// host test controller model driving test clock, mode select and data in
`timescale 1ns/1ps
`default_nettype none
module scan_host
(
	input  wire logic clk,
	input  wire logic tdoOut,
	input  wire logic tdoOe,
	output var logic  tck,
	output var logic  tms,
	output var logic  tdi
);
	int lowExtra = 0;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// -------------------------------------------
	// one clock period, tdo sampled before rise
	// -------------------------------------------
	task automatic step(input logic ms, input logic di, output logic dout);
		tms <= ms;
		tdi <= di;
		repeat (8 + lowExtra) @(posedge clk);
		dout = tdoOe ? tdoOut : 1'b1;
		tck <= 1'b1;
		repeat (8) @(posedge clk);
		tck <= 1'b0;
	endtask
	task automatic tapReset;
		logic d;
		repeat (5) step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d);
	endtask
	// scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [9:0] din, output logic [9:0] dout);
		logic d;
		dout = '0;
		step(1'b1, 1'b1, d);
		if (ir)
			step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d);
		step(1'b0, 1'b1, d);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], d);
			dout[i] = d;
		end
		step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d);
	endtask
endmodule
`default_nettype wire

// >>> tb_tap_instruction_and_debug_channel.sv
// self-checking bench for the tap instruction decode and debug channel
`timescale 1ns/1ps
`default_nettype none
module tb_tap_instruction_and_debug_channel;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       tck;
	logic       tms;
	logic       tdi;
	logic       tdoOut;
	logic       tdoOe;
	logic [1:0] engineStatus = 2'h0;
	logic [7:0] engineTxByte = 8'h00;
	logic       engineTxLoad = 1'b0;
	logic [7:0] debugBuf;
	logic       rxByteValid;
	logic [2:0] progWord;
	logic       progWordValid;
	logic [2:0] progReadback = 3'h0;
	logic [2:0] instruction;
	logic       debugActive;
	logic       programActive;
	logic [9:0] dout;
	logic [9:0] expWord;
	logic [7:0] prevBuf;
	int         error_cnt = 0;
	int         checks = 0;
	int         rxCnt = 0;
	int         progCnt = 0;
	// code, expected debug and program selection
	logic [4:0] rows [9] = '{5'h0A, 5'h02, 5'h11, 5'h05, 5'h19, 5'h14, 5'h0A, 5'h1C, 5'h0C};

	always #5 clk = ~clk;

	scan_host u_host (.clk(clk), .tdoOut(tdoOut), .tdoOe(tdoOe), .tck(tck), .tms(tms), .tdi(tdi));
	tap_instruction_and_debug_channel u_dut (.clk(clk), .rst_n(rst_n), .tckPin(tck),
		.tmsPin(tms), .tdiPin(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .engineStatus(engineStatus),
		.engineTxByte(engineTxByte), .engineTxLoad(engineTxLoad), .debug_buffer_register(debugBuf),
		.rxByteValid(rxByteValid), .progWord(progWord), .progWordValid(progWordValid),
		.progReadback(progReadback), .instruction(instruction), .debugActive(debugActive),
		.programActive(programActive));

	// counts the one-cycle update pulses so their number can be compared
	always @(posedge clk)
	begin
		if (rxByteValid === 1'b1)
			rxCnt <= rxCnt + 1;
		if (progWordValid === 1'b1)
			progCnt <= progCnt + 1;
	end

	// ----------------
	// checks and end
	// ----------------
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("instruction", 10'h3, 10'(instruction));
		chk("tdo", 10'h1, 10'({tdoOe, tdoOut}));
		u_host.tapReset();
		foreach (rows[r])
		begin
			u_host.scan(1'b1, 3, 10'(rows[r][4:2]), dout);
			chk("capture", 10'h1, dout);
			chk("instruction", 10'(rows[r][4:2]), 10'(instruction));
			chk("select", 10'(rows[r][1:0]), 10'({debugActive, programActive}));
		end
		u_host.scan(1'b0, 4, 10'h00D, dout);
		chk("bypass", 10'h00A, dout);
		chk("tdo enable", 10'h0, 10'(tdoOe));
		u_host.scan(1'b1, 3, 10'h002, dout);
		engineTxByte <= 8'hA5;
		engineTxLoad <= 1'b1;
		@(posedge clk);
		engineTxLoad <= 1'b0;
		prevBuf = 8'hA5;
		for (int k = 0; k < 5; k++)
		begin
			engineStatus <= 2'(k);
			u_host.lowExtra = (k == 2) ? 60 : 0;
			u_host.scan(1'b0, 10, {8'h3C + 8'(k), 2'b11}, dout);
			if (k > 0)
				chk("debug word", expWord, dout);
			expWord = {prevBuf, 2'(k)};
			prevBuf = 8'h3C + 8'(k);
			chk("buffer", 10'(prevBuf), 10'(debugBuf));
		end
		chk("instruction", 10'h2, 10'(instruction));
		chk("rx pulses", 10'h005, 10'(rxCnt));
		u_host.scan(1'b1, 3, 10'h004, dout);
		progReadback <= 3'h5;
		u_host.scan(1'b0, 3, 10'h006, dout);
		chk("prog word", 10'h006, 10'(progWord));
		u_host.scan(1'b0, 3, 10'h001, dout);
		chk("prog shift", 10'h005, dout);
		chk("prog pulses", 10'h002, 10'(progCnt));
		u_host.scan(1'b1, 3, 10'h002, dout);
		u_host.tapReset();
		chk("instruction", 10'h3, 10'(instruction));
		chk("select", 10'h0, 10'({debugActive, programActive}));
		u_host.scan(1'b1, 3, 10'h002, dout);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reset instruction", 10'h003, 10'(instruction));
		chk("reset select", 10'h000, 10'({debugActive, programActive}));
		chk("reset tdo", 10'h001, 10'({tdoOe, tdoOut}));
		u_host.tapReset();
		u_host.scan(1'b0, 2, 10'h001, dout);
		chk("reset path", 10'h002, dout);
		end_of_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
